// File: rtl/spi_format_baud_modefault.sv
// Serial peripheral core: formats, baud generator, select output, single wire, mode fault
`timescale 1ns/1ps

//
// Overview of operation
// - Phase zero slave drives first bit on data out as soon as select falls.
// - Phase zero: sample on first edge, shift and present next on second.
// - Phase one slave accepts back-to-back transfers with select held low.
// - Auto select low at first bit time, high half period after eighth.
// - Phase zero transfer is eight bit times, ending at last clock edge.
// - Prescaler divides bus clock by prescale field plus one, 1 to 8.
// - Rate stage divides prescaler output by a power of two, 2 to 512.
// - Total divisor is (prescale plus one) times two to (rate plus one).
// - Baud divider runs only as master during a transfer, else held off.
// - Auto select: low during transfer, high idle; master with both bits set.
// - Mode fault detection is off while select is an output.
// - Single wire mode: master uses master-out pin, slave uses master-in pin.
// - Single wire output enable sets direction; same pin feeds shift input.
// - Clock out as master, in as slave; select per mode; single wire no effect.
// - Select low as master with fault detect enabled sets the fault flag.
// - Master without fault detect ignores select; slaves never raise faults.
// - Fault clears master bit, releases all pins, aborts transfer to idle.
// - Fault as single wire master clears output enable; slaves never fault.
// - Fault flag clears on status read while set, then control one write.
// - System enable clear stops the core; registers stay accessible.
// - Stop-in-wait set halts master transfer during wait, resumes after.
// - Fault flag set with interrupt enable raises the interrupt request.
// - Deselected slave floats data out, ignores clock, forced to idle.
module spi_format_baud_modefault #(
    parameter int ADDR_W = 5
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_wait_mode,
    input wire spi_pkg::spi_pin_in_s i_pins,
    output spi_pkg::spi_pin_out_s o_pins,
    output logic o_irq
);
    import spi_pkg::*;

    // Parameter check
    generate
        if (ADDR_W < 5) begin : g_bad_addr
            $error("ADDR_W must be at least 5");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Bit presented on the data out pin
    function automatic logic tx_bit(input logic [7:0] sh, input logic lsbf);
        tx_bit = lsbf ? sh[0] : sh[7];
    endfunction : tx_bit

    // Shift one bit in at the end opposite to the outgoing bit
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                            input logic lsbf);
        shift_in = lsbf ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : shift_in

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flip-flops each
    logic [3:0] pin_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    spi_pin_in_s pin_s;

    assign pin_raw = i_pins;
    generate
        for (genvar gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge i_sys_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    assign pin_s = sync2_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register state and shared signals
    logic irq_en_q, sys_en_q, master_q, clock_polarity_sel_q, clock_phase_sel_q, soe_q, lsbf_q;
    logic fde_q, swoe_q, siw_q, swe_q;
    logic [2:0] psc_q;
    logic [3:0] spr_q;
    logic rx_full_q, tx_empty_q, fault_q, armed_q;
    logic [7:0] tx_q, rx_q, sh_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic req, wr_acc, rd_acc;
    logic active, halt, fault_set;
    master_state_e mst_q;
    logic [2:0] pre_q;
    logic [7:0] rate_q;
    logic [7:0] rate_top;
    logic [3:0] spr_eff;
    logic gen_run, half_tick;
    logic sck_lvl_q, sck_p_q, samp_bit_q;
    logic [4:0] edge_q, edge_k;
    logic edge_ev, in_bit, sel_s, m_drv;
    logic samp_e, shift_e, last_e, shift_bit;
    logic m_start, s_load, load_ev;
    logic [7:0] sh_shifted;
    spi_pin_out_s pins_d;

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, effect at the acknowledging edge
    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_q;
    assign wr_acc = i_avs_write & ack_q & i_avs_byteenable[0];
    assign rd_acc = i_avs_read & ack_q;

    // Acknowledge toggle
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data capture, unmapped offsets read zero
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_avs_read & ~ack_q) begin
            rdata_q <= 32'h0000_0000;
            unique case (i_avs_address[4:0])
                OFF_CTRL1: begin
                    rdata_q[7:0] <= {irq_en_q, sys_en_q, 1'b0, master_q,
                                     clock_polarity_sel_q, clock_phase_sel_q, soe_q, lsbf_q};
                end
                OFF_CTRL2: begin
                    rdata_q[7:0] <= {3'h0, fde_q, swoe_q, 1'b0, siw_q, swe_q};
                end
                OFF_BAUD: begin
                    rdata_q[7:0] <= {1'b0, psc_q, spr_q};
                end
                OFF_STATUS: begin
                    rdata_q[7:0] <= {rx_full_q, 1'b0, tx_empty_q, fault_q, 4'h0};
                end
                OFF_DATA: begin
                    rdata_q[7:0] <= rx_q;
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end
    end
    assign o_avs_readdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Core enable and wait halt
    // core gating
    assign active = sys_en_q;
    assign halt = i_wait_mode & siw_q;

    assign fault_set = active & master_q & fde_q & ~soe_q & ~pin_s.ss_n;

    // Control one; a fault overrides a same-cycle write of the master bit
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {irq_en_q, sys_en_q} <= {CTRL1_RST[C1_IRQ_EN], CTRL1_RST[C1_SYS_EN]};
            master_q <= CTRL1_RST[C1_MASTER];
            {clock_polarity_sel_q, clock_phase_sel_q} <= {CTRL1_RST[C1_CLOCK_POLARITY_SEL], CTRL1_RST[C1_CLOCK_PHASE_SEL]};
            {soe_q, lsbf_q} <= {CTRL1_RST[C1_SOE], CTRL1_RST[C1_LSBF]};
        end else begin
            if (wr_acc && i_avs_address[4:0] == OFF_CTRL1) begin
                irq_en_q <= i_avs_writedata[C1_IRQ_EN];
                sys_en_q <= i_avs_writedata[C1_SYS_EN];
                master_q <= i_avs_writedata[C1_MASTER];
                clock_polarity_sel_q <= i_avs_writedata[C1_CLOCK_POLARITY_SEL];
                clock_phase_sel_q <= i_avs_writedata[C1_CLOCK_PHASE_SEL];
                soe_q <= i_avs_writedata[C1_SOE];
                lsbf_q <= i_avs_writedata[C1_LSBF];
            end
            if (fault_set) begin
                master_q <= 1'b0;
            end
        end
    end

    // Control two and baud fields
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {fde_q, swoe_q} <= {CTRL2_RST[C2_FDE], CTRL2_RST[C2_SWOE]};
            {siw_q, swe_q} <= {CTRL2_RST[C2_SIW], CTRL2_RST[C2_SWE]};
            psc_q <= BAUD_RST[BD_PSC_LSB +: 3];
            spr_q <= BAUD_RST[BD_SPR_LSB +: 4];
        end else begin
            if (wr_acc && i_avs_address[4:0] == OFF_CTRL2) begin
                fde_q <= i_avs_writedata[C2_FDE];
                swoe_q <= i_avs_writedata[C2_SWOE];
                siw_q <= i_avs_writedata[C2_SIW];
                swe_q <= i_avs_writedata[C2_SWE];
            end
            if (wr_acc && i_avs_address[4:0] == OFF_BAUD) begin
                psc_q <= i_avs_writedata[BD_PSC_LSB +: 3];
                spr_q <= i_avs_writedata[BD_SPR_LSB +: 4];
            end
            if (fault_set && swe_q) begin
                swoe_q <= 1'b0;
            end
        end
    end

    // fault flag: set wins over the read-then-write clear
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fault_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            if (rd_acc && i_avs_address[4:0] == OFF_STATUS && fault_q) begin
                armed_q <= 1'b1;
            end else if (wr_acc && i_avs_address[4:0] == OFF_CTRL1) begin
                armed_q <= 1'b0;
                if (armed_q) begin
                    fault_q <= 1'b0;
                end
            end
            if (fault_set) begin
                fault_q <= 1'b1;
            end
        end
    end

    // Transmit buffer and flags; a new write beats the load that empties it
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_q <= 8'h00;
            tx_empty_q <= 1'b1;
        end else begin
            if (load_ev) begin
                tx_empty_q <= 1'b1;
            end
            if (wr_acc && i_avs_address[4:0] == OFF_DATA) begin
                tx_q <= i_avs_writedata[7:0];
                tx_empty_q <= 1'b0;
            end
        end
    end

    // Receive buffer; a full buffer drops the newer byte
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_q <= 8'h00;
            rx_full_q <= 1'b0;
        end else begin
            if (rd_acc && i_avs_address[4:0] == OFF_DATA) begin
                rx_full_q <= 1'b0;
            end
            if (edge_ev && last_e && !rx_full_q) begin
                rx_q <= sh_shifted;
                rx_full_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baud generator
    assign spr_eff = (spr_q > SPR_MAX) ? SPR_MAX : spr_q;
    // half period length of the rate stage
    assign rate_top = 8'((9'h001 << spr_eff) - 9'h001);
    // run only as master in transfer
    assign gen_run = active & master_q & (mst_q != ST_IDLE);
    assign half_tick = gen_run & ~halt & (pre_q == psc_q) & (rate_q == rate_top);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_q <= 3'h0;
            rate_q <= 8'h00;
        end else if (!gen_run) begin
            pre_q <= 3'h0;
            rate_q <= 8'h00;
        end else if (!halt) begin
            if (pre_q == psc_q) begin
                pre_q <= 3'h0;
                rate_q <= (rate_q == rate_top) ? 8'h00 : rate_q + 8'h01;
            end else begin
                pre_q <= pre_q + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master sequencer: lead half period, sixteen edges, trail half period
    assign m_start = (mst_q == ST_IDLE) & active & master_q & ~tx_empty_q & ~fault_set;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mst_q <= ST_IDLE;
        end else if (!active || !master_q || fault_set) begin
            mst_q <= ST_IDLE;
        end else begin
            unique case (mst_q)
                ST_IDLE: begin
                    if (m_start) begin
                        mst_q <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (half_tick) begin
                        mst_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (edge_ev && last_e) begin
                        mst_q <= ST_TRAIL;
                    end
                end
                ST_TRAIL: begin
                    if (half_tick) begin
                        mst_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Master clock level, back at idle after an even edge count
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sck_lvl_q <= 1'b0;
        end else if (mst_q == ST_IDLE) begin
            sck_lvl_q <= 1'b0;
        end else if (edge_ev && master_q) begin
            sck_lvl_q <= ~sck_lvl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge source and serial input for both roles
    // slave selection
    assign sel_s = active & ~master_q & ~pin_s.ss_n;
    assign m_drv = active & master_q;

    // Previous synchronised clock level for slave edge detection
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sck_p_q <= 1'b1;
        end else begin
            sck_p_q <= pin_s.sck;
        end
    end

    always_comb begin
        if (master_q) begin
            edge_ev = ((mst_q == ST_LEAD) | (mst_q == ST_RUN)) & half_tick;
            in_bit = swe_q ? pin_s.mosi : pin_s.miso;
        end else begin
            edge_ev = sel_s & (pin_s.sck != sck_p_q);
            in_bit = swe_q ? pin_s.miso : pin_s.mosi;
        end
    end

    // edge roles: sample on one edge, shift on the other
    assign edge_k = edge_q + 5'h01;
    assign samp_e = edge_k[0] ^ clock_phase_sel_q;
    assign shift_e = ~samp_e & ~(clock_phase_sel_q & (edge_k == 5'h01));
    assign last_e = (edge_k == EDGES_PER_XFER);
    assign shift_bit = (clock_phase_sel_q & last_e) ? in_bit : samp_bit_q;
    assign sh_shifted = shift_in(sh_q, shift_bit, lsbf_q);

    // slave loads a waiting transmit byte while no edge has been seen yet
    assign s_load = active & ~master_q & (edge_q == 5'h00) & ~tx_empty_q & ~edge_ev;
    assign load_ev = m_start | s_load;

    // Shift engine and edge counter
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            edge_q <= 5'h00;
            sh_q <= 8'h00;
            samp_bit_q <= 1'b0;
        end else if (!active || fault_set) begin
            edge_q <= 5'h00;
        end else if (!master_q && pin_s.ss_n) begin
            edge_q <= 5'h00;
            if (s_load) begin
                sh_q <= tx_q;
            end
        end else if (load_ev) begin
            sh_q <= tx_q;
            edge_q <= 5'h00;
        end else if (edge_ev) begin
            edge_q <= last_e ? 5'h00 : edge_k;
            if (samp_e) begin
                samp_bit_q <= in_bit;
            end
            if (shift_e || (clock_phase_sel_q && last_e)) begin
                sh_q <= sh_shifted;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive
    always_comb begin
        pins_d.sck_oe = m_drv;
        pins_d.sck_o = sck_lvl_q ^ clock_polarity_sel_q;
        // data pins by role and single wire direction
        pins_d.mosi_oe = m_drv & (~swe_q | swoe_q);
        pins_d.mosi_o = tx_bit(sh_q, lsbf_q);
        pins_d.miso_oe = sel_s & ~fault_q & (~swe_q | swoe_q);
        pins_d.miso_o = tx_bit(sh_q, lsbf_q);
        pins_d.ss_n_oe = m_drv & fde_q & soe_q;
        pins_d.ss_n_o = (mst_q == ST_IDLE);
        // release every pin on a fault
        if (fault_set) begin
            pins_d = '0;
        end
    end

    // Registered pin and interrupt outputs
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pins <= '0;
            o_irq <= 1'b0;
        end else begin
            o_pins <= pins_d;
            o_irq <= sys_en_q & irq_en_q & (fault_q | rx_full_q);
        end
    end

endmodule : spi_format_baud_modefault

// File: rtl/spi_pkg.sv
// Shared constants, types and pin carriers of the serial peripheral core
package spi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] OFF_CTRL1 = 5'h00;
    localparam logic [4:0] OFF_CTRL2 = 5'h04;
    localparam logic [4:0] OFF_BAUD = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0C;
    localparam logic [4:0] OFF_DATA = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Control one field positions
    localparam int C1_IRQ_EN = 7;
    localparam int C1_SYS_EN = 6;
    localparam int C1_MASTER = 4;
    localparam int C1_CLOCK_POLARITY_SEL = 3;
    localparam int C1_CLOCK_PHASE_SEL = 2;
    localparam int C1_SOE = 1;
    localparam int C1_LSBF = 0;
    // Control two field positions
    localparam int C2_FDE = 4;
    localparam int C2_SWOE = 3;
    localparam int C2_SIW = 1;
    localparam int C2_SWE = 0;
    // Baud field positions
    localparam int BD_PSC_LSB = 4;
    localparam int BD_SPR_LSB = 0;
    // Status field positions
    localparam int ST_RX_FULL = 7;
    localparam int ST_TX_EMPTY = 5;
    localparam int ST_FAULT = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset and counts
    localparam logic [7:0] CTRL1_RST = 8'h04;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [3:0] SPR_MAX = 4'h8;
    localparam logic [4:0] EDGES_PER_XFER = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Master sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_RUN, ST_TRAIL} master_state_e;

    // Synchronised pin levels
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } spi_pin_in_s;

    // Pin drive levels and enables
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic ss_n_o;
        logic ss_n_oe;
    } spi_pin_out_s;

endpackage : spi_pkg

// File: dv/spi_fbm_checker.sv
// Pin and bus handshake checks of the serial core
`timescale 1ns/1ps
module spi_fbm_checker
    import spi_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire spi_pkg::spi_pin_in_s i_pins,
    input wire spi_pkg::spi_pin_out_s o_pins
);
    logic [4:0] edge_q;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    ////////////////////////////////////////////////////////////////////////////
    // Clock edges seen while select is low
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            edge_q <= 5'h00;
        end else if (o_pins.ss_n_o) begin
            edge_q <= 5'h00;
        end else if ($changed(o_pins.sck_o)) begin
            edge_q <= edge_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one wait cycle
    property p_one_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer late");
    property p_roles;
        o_pins.miso_oe |-> !o_pins.mosi_oe && !o_pins.sck_oe;
    endproperty
    a_roles: assert property (p_roles) else $error("slave drives master pins");
    property p_sck_sel;
        $changed(o_pins.sck_o) && o_pins.sck_oe |-> !o_pins.ss_n_o;
    endproperty
    a_sck_sel: assert property (p_sck_sel) else $error("clock moved while idle");
    property p_release;
        $fell(o_pins.sck_oe) |-> !o_pins.mosi_oe && !o_pins.ss_n_oe;
    endproperty
    a_release: assert property (p_release) else $error("pins not released");
    property p_float;
        !o_pins.sck_oe && i_pins.ss_n [*4] |=> !o_pins.miso_oe;
    endproperty
    a_float: assert property (p_float) else $error("deselected slave drives");
    property p_edges;
        $rose(o_pins.ss_n_o) && o_pins.ss_n_oe |-> edge_q == 5'h10;
    endproperty
    a_edges: assert property (p_edges) else $error("wrong edge count");
    property p_lead;
        $fell(o_pins.ss_n_o) |-> $stable(o_pins.sck_o);
    endproperty
    a_lead: assert property (p_lead) else $error("no lead before clock");
    property p_no_fault;
        o_pins.ss_n_oe |=> o_pins.sck_oe;
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("fault with select out");
endmodule : spi_fbm_checker

bind spi_format_baud_modefault spi_fbm_checker i_chk (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_pins(i_pins),
    .o_pins(o_pins)
);

// File: dv/spi_far_slave.sv
// Far-side slave, phase zero, polarity zero, high bit first
`timescale 1ns/1ps
module spi_far_slave (
    input wire logic i_sck,
    input wire logic i_ss_n,
    input wire logic i_mosi,
    input wire logic [7:0] i_tx,
    output logic o_miso,
    output logic [7:0] o_rx
);
    logic [7:0] sh;
    logic bit_q;
    int cnt;
    initial begin
        o_miso = 1'b0;
        o_rx = 8'h00;
    end
    // first bit at select, line inverted after release
    always @(i_ss_n) begin
        if (!i_ss_n) begin
            sh = i_tx;
            cnt = 0;
            o_miso = i_tx[7];
        end else begin
            o_miso = ~o_miso;
        end
    end
    always @(posedge i_sck) begin
        if (!i_ss_n) bit_q = i_mosi;
    end
    // shift on second edge, eight bits
    always @(negedge i_sck) begin
        if (!i_ss_n) begin
            sh = {sh[6:0], bit_q};
            o_miso = sh[7];
            cnt++;
            if (cnt == 8) o_rx = sh;
        end
    end
endmodule : spi_far_slave

// File: dv/tb_top.sv
// Self-checking bench of the serial core
`timescale 1ns/1ps
module tb_top;
    import spi_pkg::*;
    logic i_sys_clk, i_nrst, rd, wr, wq, irq, miso_m, ss_low, wt;
    logic [4:0] adr;
    logic [31:0] wd, rdat, seed;
    logic [7:0] far_tx, far_rx, q;
    spi_pin_in_s pin_in;
    spi_pin_out_s pin_out;
    int errors, num_checks, p, s;
    byte unsigned exp_q[$];

    spi_format_baud_modefault i_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
        .i_wait_mode(wt), .i_pins(pin_in), .o_pins(pin_out), .o_irq(irq));
    spi_far_slave i_far (.i_sck(pin_in.sck), .i_ss_n(pin_in.ss_n), .i_mosi(pin_in.mosi),
        .i_tx(far_tx), .o_miso(miso_m), .o_rx(far_rx));
    // Wire levels from all drivers, select pulled high
    assign pin_in = {pin_out.sck_oe & pin_out.sck_o,
        pin_out.mosi_oe ? pin_out.mosi_o : ~pin_out.mosi_o,
        pin_out.miso_oe ? pin_out.miso_o : miso_m,
        pin_out.ss_n_oe ? pin_out.ss_n_o : ~ss_low};

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : nxt
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One bus cycle, held until waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        @(posedge i_sys_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {24'h00_0000, d};
        @(posedge i_sys_clk);
        while (wq !== 1'b0) @(posedge i_sys_clk);
        r = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // One master byte, gaps measured in cycles
    task automatic xfer(input logic [7:0] tx, input logic [7:0] slv, input int h);
        int n, t0, t1, t2;
        n = 0;
        far_tx = slv;
        exp_q.push_back(slv);
        bus(1'b1, OFF_DATA, tx, q);
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (pin_out.ss_n_o !== 1'b0 && n < 5000);
        t0 = n;
        while (pin_out.sck_o !== 1'b1 && n < 5000) begin @(negedge i_sys_clk); n++; end
        t1 = n;
        while (pin_out.sck_o !== 1'b0 && n < 5000) begin @(negedge i_sys_clk); n++; end
        t2 = n;
        while (pin_out.ss_n_o !== 1'b1 && n < 5000) begin @(negedge i_sys_clk); n++; end
        chk("lead", h, t1 - t0);
        chk("half", h, t2 - t1);
        chk("mosi", tx, far_rx);
        bus(1'b0, OFF_DATA, 8'h00, q);
        chk("miso", exp_q.pop_front(), q);
    endtask : xfer
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #500_000;
        errors++;
        summarize();
    end
    initial begin
        {i_nrst, rd, wr, ss_low, wt} = 5'h00;
        adr = 5'h00;
        wd = 32'h0000_0000;
        far_tx = 8'h00;
        seed = 32'h0000_da6b;
        repeat (12) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        bus(1'b0, OFF_CTRL1, 8'h00, q);
        chk("ctrl1", CTRL1_RST, q);
        bus(1'b1, OFF_BAUD, 8'h35, q);
        bus(1'b0, OFF_BAUD, 8'h00, q);
        chk("baud", 8'h35, q);
        bus(1'b0, 5'h14, 8'h00, q);
        chk("unmapped", 8'h00, q);
        $display("test registers done");
        bus(1'b1, OFF_CTRL2, 8'h10, q);
        bus(1'b1, OFF_CTRL1, 8'h52, q);
        for (int i = 0; i < 4; i++) begin
            seed = nxt();
            p = seed % 8;
            s = (seed >> 4) % 3;
            // Round trip through output register and synchronisers needs four cycles
            if (((p + 1) << s) < 4) s = 2;
            bus(1'b1, OFF_BAUD, 8'(p * 16 + s), q);
            xfer(seed[15:8], seed[23:16], (p + 1) << s);
        end
        // Wait with stop-in-wait set freezes the master, release resumes it
        bus(1'b1, OFF_CTRL2, 8'h12, q);
        wt <= 1'b1;
        bus(1'b1, OFF_DATA, 8'hA5, q);
        repeat (99) @(posedge i_sys_clk);
        chk("halt", 2'b00, {pin_out.sck_o, pin_out.ss_n_o});
        wt <= 1'b0;
        repeat (900) @(posedge i_sys_clk);
        chk("resume", 8'hA5, far_rx);
        bus(1'b0, OFF_DATA, 8'h00, q);
        chk("miso", far_tx, q);
        $display("test transfers done");
        bus(1'b1, OFF_CTRL1, 8'hD0, q);
        ss_low <= 1'b1;
        repeat (8) @(posedge i_sys_clk);
        bus(1'b0, OFF_STATUS, 8'h00, q);
        chk("fault", 1'b1, q[ST_FAULT]);
        chk("irq", 1'b1, irq);
        chk("oe", 3'h0, {pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe});
        ss_low <= 1'b0;
        bus(1'b0, OFF_CTRL1, 8'h00, q);
        chk("ctrl1", 8'hC0, q);
        bus(1'b1, OFF_CTRL1, 8'hD0, q);
        bus(1'b0, OFF_STATUS, 8'h00, q);
        chk("fault", 1'b0, q[ST_FAULT]);
        chk("irq", 1'b0, irq);
        bus(1'b1, OFF_CTRL2, 8'h00, q);
        ss_low <= 1'b1;
        repeat (8) @(posedge i_sys_clk);
        bus(1'b0, OFF_STATUS, 8'h00, q);
        chk("fault", 1'b0, q[ST_FAULT]);
        bus(1'b0, OFF_CTRL1, 8'h00, q);
        chk("ctrl1", 8'hD0, q);
        ss_low <= 1'b0;
        $display("test fault done");
        summarize();
    end
endmodule : tb_top
